// *** src/smb_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module smb_master
  import smb_pkg::*;
(
  // System clock domain.
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial link clock domain.
  input  wire logic              link_clk,
  // Control inputs.
  input  wire logic              module_enable_bit,
  input  wire logic              fifo_buffer_enable,
  input  wire logic              clk_edge_select,
  input  wire logic              clk_idle_high,
  input  wire logic              slave_select_enable,
  input  wire logic              sleep_req,
  input  wire logic [2:0]        buffer_irq_select,
  input  wire logic              irq_clear,
  // Transmit words.
  input  wire logic              tx_valid,
  output var  logic              tx_ready,
  input  wire logic [WORD_W-1:0] tx_data,
  // Received words.
  output var  logic              rx_valid,
  input  wire logic              rx_ready,
  output logic      [WORD_W-1:0] rx_data,
  // Status.
  output var  logic              rx_buffer_full_flag,
  output var  logic              shifter_empty_flag,
  output var  logic              serial_irq_flag,
  output var  logic [STAT_W-1:0] serial_status_reg,
  // Serial pins.
  output var  logic              sck,
  output var  logic              mosi,
  input  wire logic              miso,
  output var  logic              ss_n
);

  // ---------------- System domain signals ----------------
  logic              tx_out_valid;   // Word waiting for the shifter.
  logic [WORD_W-1:0] tx_out_data;    // That word.
  logic [CNT_W-1:0]  tx_cnt;         // Transmit occupancy.
  logic              rx_in_ready;    // Room for a received word.
  logic [CNT_W-1:0]  rx_cnt;         // Receive occupancy.
  logic              issue;          // Hand a word to the link side.
  logic              busy_r;         // A word is in flight.
  logic              req_tgl_r;      // Request toggle to the link side.
  logic [WORD_W-1:0] xfer_data_r;    // Word held stable for the link.
  logic              done_s1_r;      // Done toggle, first stage.
  logic              done_s2_r;      // Done toggle, second stage.
  logic              done_seen_r;    // Last done toggle handled.
  logic              done_pulse;     // One cycle per finished word.
  logic              sr_done_r;      // Finish with nothing pending.
  logic [CNT_W-1:0]  tx_cnt_prev_r;  // Occupancy one cycle ago.
  logic [CNT_W-1:0]  rx_cnt_prev_r;  // Occupancy one cycle ago.
  logic [7:0]        ev;             // The eight buffer events.
  logic              irq_set;        // Selected event this cycle.

  // ---------------- Link domain signals ----------------
  smb_link_state_e   lk_state_r;     // Shifter state.
  logic              req_s1_r;       // Request toggle, first stage.
  logic              req_s2_r;       // Request toggle, second stage.
  logic              req_seen_r;     // Last request handled.
  logic              en_s1_r;        // Enable, first stage.
  logic              en_s2_r;        // Enable, second stage.
  logic              cke_s1_r;       // Edge select, first stage.
  logic              cke_s2_r;       // Edge select, second stage.
  logic              cpol_s1_r;      // Idle level, first stage.
  logic              cpol_s2_r;      // Idle level, second stage.
  logic              miso_s1_r;      // Serial input, first stage.
  logic              miso_s2_r;      // Serial input, second stage.
  logic [HALF_W-1:0] ph_r;           // Cycle within a half bit.
  logic              half_r;         // Zero leading half, one trailing.
  logic [3:0]        bit_r;          // Bit number within the word.
  logic [WORD_W-1:0] tx_sh_r;        // Outgoing shift register.
  logic [WORD_W-1:0] rx_sh_r;        // Incoming shift register.
  logic [WORD_W-1:0] rx_sh_nxt;      // Incoming word after a sample.
  logic [WORD_W-1:0] rx_hold_r;      // Finished word for the system side.
  logic              done_tgl_r;     // Done toggle to the system side.
  logic              req_edge;       // New request seen.
  logic              change_half;    // Half in which data changes.
  logic              sample_now;     // Capture point for the input.

  // Transmit buffer; in standard mode it holds one word only.
  smb_pair_buf u_tx_buf (
    .clk       (clk),
    .rst       (rst),
    .flush     (!module_enable_bit),
    .single    (!fifo_buffer_enable),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (tx_out_valid),
    .out_ready (issue),
    .out_data  (tx_out_data),
    .count     (tx_cnt)
  );

  // Receive buffer; a full buffer holds off the next transfer.
  smb_pair_buf u_rx_buf (
    .clk       (clk),
    .rst       (rst),
    .flush     (!module_enable_bit),
    .single    (!fifo_buffer_enable),
    .in_valid  (done_pulse && module_enable_bit),
    .in_ready  (rx_in_ready),
    .in_data   (rx_hold_r),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .count     (rx_cnt)
  );

  // A word leaves only when one is really queued; nothing is invented
  // after sleep, so an empty queue never produces null traffic.
  assign issue = module_enable_bit && !sleep_req && !busy_r
              && tx_out_valid && rx_in_ready;

  // Done toggle crossing; only the second stage is compared.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_s1_r   <= 1'b0;
      done_s2_r   <= 1'b0;
      done_seen_r <= 1'b0;
    end else begin
      done_s1_r   <= done_tgl_r;
      done_s2_r   <= done_s1_r;
      done_seen_r <= done_s2_r;
    end
  end

  assign done_pulse = done_s2_r ^ done_seen_r;

  // Request handshake. The held word stays put until the link answers,
  // which is what makes the multi-bit crossing safe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r      <= 1'b0;
      req_tgl_r   <= 1'b0;
      xfer_data_r <= '0;
    end else if (issue) begin
      busy_r      <= 1'b1;
      req_tgl_r   <= !req_tgl_r;
      xfer_data_r <= tx_out_data;
    end else if (done_pulse) begin
      busy_r      <= 1'b0;
    end
  end

  // Event history, one cycle behind the buffers, so flags and the
  // interrupt all change on the same edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cnt_prev_r <= CNT_ZERO;
      rx_cnt_prev_r <= CNT_ZERO;
      sr_done_r     <= 1'b0;
    end else begin
      tx_cnt_prev_r <= tx_cnt;
      rx_cnt_prev_r <= rx_cnt;
      sr_done_r     <= done_pulse && !tx_out_valid;
    end
  end

  // The eight buffer events.
  always_comb begin
    ev[SEL_RX_EMPTIED] = (rx_cnt == CNT_ZERO) && (rx_cnt_prev_r != CNT_ZERO);
    ev[SEL_RX_ARRIVED] = (rx_cnt > rx_cnt_prev_r);
    ev[SEL_RX_FULL]    = (rx_cnt == CNT_FULL) && (rx_cnt_prev_r != CNT_FULL);
    ev[SEL_TX_NOTFULL] = (tx_cnt != CNT_FULL) && (tx_cnt_prev_r == CNT_FULL);
    ev[SEL_TX_STARTED] = (tx_cnt < tx_cnt_prev_r);
    ev[SEL_SR_EMPTY]   = sr_done_r;
    // With slave select in use both empty events share one moment.
    ev[SEL_TX_EMPTIED] = slave_select_enable ? sr_done_r
                       : (tx_cnt == CNT_ZERO) && (tx_cnt_prev_r != CNT_ZERO);
    ev[SEL_TX_FULL]    = (tx_cnt == CNT_FULL) && (tx_cnt_prev_r != CNT_FULL);
  end

  // Standard mode interrupts once per received word; the FIFO mode uses
  // the three-bit selection.
  always_comb begin
    if (fifo_buffer_enable) begin
      irq_set = ev[buffer_irq_select];
    end else begin
      irq_set = ev[SEL_RX_ARRIVED];
    end
  end

  // Sticky interrupt flag; a set in the clearing cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_irq_flag <= 1'b0;
    end else if (module_enable_bit && irq_set) begin
      serial_irq_flag <= 1'b1;
    end else if (irq_clear || !module_enable_bit) begin
      serial_irq_flag <= 1'b0;
    end
  end

  // Status flags and status word, registered from buffer occupancy, shifter state and control inputs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buffer_full_flag <= 1'b0;
      shifter_empty_flag  <= 1'b1;
      serial_status_reg   <= '0;
    end else begin
      rx_buffer_full_flag <= fifo_buffer_enable ? (rx_cnt == CNT_FULL)
                                                : (rx_cnt != CNT_ZERO);
      shifter_empty_flag  <= !busy_r && !tx_out_valid;
      serial_status_reg   <= '0;
      serial_status_reg[STAT_RXFULL_BIT] <= fifo_buffer_enable
                          ? (rx_cnt == CNT_FULL) : (rx_cnt != CNT_ZERO);
      serial_status_reg[STAT_TXFULL_BIT] <= !tx_ready;
      serial_status_reg[STAT_SEL_MSB:STAT_SEL_LSB] <= buffer_irq_select;
      serial_status_reg[STAT_SREMPTY_BIT] <= !busy_r && !tx_out_valid;
      serial_status_reg[STAT_FIFOEN_BIT]  <= fifo_buffer_enable;
      serial_status_reg[STAT_ENABLE_BIT]  <= module_enable_bit;
    end
  end

  // ---------------- Link domain ----------------

  // Two-stage synchronisers for every single-bit signal entering this domain; the held word is read directly.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      en_s1_r   <= 1'b0;
      en_s2_r   <= 1'b0;
      cke_s1_r  <= 1'b0;
      cke_s2_r  <= 1'b0;
      cpol_s1_r <= 1'b0;
      cpol_s2_r <= 1'b0;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      req_s1_r  <= req_tgl_r;
      req_s2_r  <= req_s1_r;
      en_s1_r   <= module_enable_bit;
      en_s2_r   <= en_s1_r;
      cke_s1_r  <= clk_edge_select;
      cke_s2_r  <= cke_s1_r;
      cpol_s1_r <= clk_idle_high;
      cpol_s2_r <= cpol_s1_r;
      miso_s1_r <= miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  assign req_edge = req_s2_r ^ req_seen_r;

  // Edge select one moves data on the trailing (active to idle) half;
  // zero moves it on the leading half. Sampling is the other half, at
  // its last cycle, which absorbs the two-stage input latency.
  assign change_half = cke_s2_r ? half_r : !half_r;
  assign sample_now  = !change_half && (ph_r == PH_LAST);
  assign rx_sh_nxt   = sample_now ? {rx_sh_r[MSB-1:0], miso_s2_r} : rx_sh_r;

  // Shifter. Completion is reported only after the trailing half of the
  // last bit, so the final clock edge is already on the pin; the select
  // is released on that same edge, before any status flag can move.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_state_r <= SMB_LK_IDLE;
      req_seen_r <= 1'b0;
      done_tgl_r <= 1'b0;
      ph_r       <= PH_FIRST;
      half_r     <= 1'b0;
      bit_r      <= BIT_FIRST;
      tx_sh_r    <= '0;
      rx_sh_r    <= '0;
      rx_hold_r  <= '0;
      sck        <= 1'b0;
      mosi       <= 1'b0;
      ss_n       <= 1'b1;
    end else begin
      case (lk_state_r)
        SMB_LK_IDLE: begin
          sck  <= cpol_s2_r;
          ss_n <= 1'b1;
          if (req_edge) begin
            req_seen_r <= req_s2_r;
            if (!en_s2_r) begin
              done_tgl_r <= !done_tgl_r;
            end else begin
              lk_state_r <= SMB_LK_SHIFT;
              ph_r       <= PH_FIRST;
              half_r     <= 1'b0;
              bit_r      <= BIT_FIRST;
              rx_sh_r    <= '0;
              ss_n       <= 1'b0;
              if (cke_s2_r) begin
                mosi    <= xfer_data_r[MSB];
                tx_sh_r <= {xfer_data_r[MSB-1:0], 1'b0};
              end else begin
                tx_sh_r <= xfer_data_r;
              end
            end
          end
        end
        SMB_LK_SHIFT: begin
          if (!en_s2_r) begin
            // Disable aborts the word and still answers the request.
            lk_state_r <= SMB_LK_IDLE;
            done_tgl_r <= !done_tgl_r;
            sck        <= cpol_s2_r;
            ss_n       <= 1'b1;
          end else begin
            ph_r    <= ph_r + 1'b1;
            rx_sh_r <= rx_sh_nxt;
            if (ph_r == PH_FIRST) begin
              sck <= half_r ? cpol_s2_r : !cpol_s2_r;
              if (change_half) begin
                mosi    <= tx_sh_r[MSB];
                tx_sh_r <= {tx_sh_r[MSB-1:0], 1'b0};
              end
            end
            if (ph_r == PH_LAST) begin
              half_r <= !half_r;
              if (half_r) begin
                if (bit_r == BIT_LAST) begin
                  lk_state_r <= SMB_LK_IDLE;
                  ss_n       <= 1'b1;
                  rx_hold_r  <= rx_sh_nxt;
                  done_tgl_r <= !done_tgl_r;
                end else begin
                  bit_r <= bit_r + 1'b1;
                end
              end
            end
          end
        end
        default: begin
          lk_state_r <= SMB_LK_IDLE;
        end
      endcase
    end
  end

endmodule : smb_master

`default_nettype wire

// *** src/smb_pkg.sv ***
package smb_pkg;

  // Word and buffer geometry.
  localparam int              WORD_W    = 16;
  localparam int              CNT_W     = 2;
  localparam int              BUF_DEPTH = 2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;
  localparam logic [CNT_W-1:0] CNT_FULL = 2'h2;

  // Serial timing: link clock cycles per half bit, and bits per word.
  localparam int             HALF_W    = 2;
  localparam logic [HALF_W-1:0] PH_FIRST = 2'h0;
  localparam logic [HALF_W-1:0] PH_LAST  = 2'h3;
  localparam logic [3:0]     BIT_FIRST = 4'h0;
  localparam logic [3:0]     BIT_LAST  = 4'hF;
  localparam int             MSB       = WORD_W - 1;

  // Status word layout.
  localparam int STAT_W          = 16;
  localparam int STAT_RXFULL_BIT = 0;
  localparam int STAT_TXFULL_BIT = 1;
  localparam int STAT_SEL_LSB    = 2;
  localparam int STAT_SEL_MSB    = 4;
  localparam int STAT_SREMPTY_BIT = 7;
  localparam int STAT_FIFOEN_BIT = 11;
  localparam int STAT_ENABLE_BIT = 15;

  // Buffer interrupt selections.
  localparam logic [2:0] SEL_RX_EMPTIED  = 3'h0;
  localparam logic [2:0] SEL_RX_ARRIVED  = 3'h1;
  localparam logic [2:0] SEL_RX_FULL     = 3'h2;
  localparam logic [2:0] SEL_TX_NOTFULL  = 3'h3;
  localparam logic [2:0] SEL_TX_STARTED  = 3'h4;
  localparam logic [2:0] SEL_SR_EMPTY    = 3'h5;
  localparam logic [2:0] SEL_TX_EMPTIED  = 3'h6;
  localparam logic [2:0] SEL_TX_FULL     = 3'h7;

  // Link side shifter states.
  typedef enum logic [1:0] {
    SMB_LK_IDLE  = 2'b01,
    SMB_LK_SHIFT = 2'b10
  } smb_link_state_e;

endpackage : smb_pkg

// *** src/smb_pair_buf.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; all flags are registered so the top sees flop outputs.
module smb_pair_buf
  import smb_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Control.
  input  wire logic              flush,
  input  wire logic              single,
  // Fill side.
  input  wire logic              in_valid,
  output var  logic              in_ready,
  input  wire logic [WORD_W-1:0] in_data,
  // Drain side.
  output var  logic              out_valid,
  input  wire logic              out_ready,
  output logic      [WORD_W-1:0] out_data,
  output var  logic [CNT_W-1:0]  count
);

  logic [WORD_W-1:0] mem [BUF_DEPTH];  // Storage entries.
  logic              wr_r;             // Write pointer.
  logic              rd_r;             // Read pointer.
  logic              push;             // Word accepted this cycle.
  logic              pop;              // Word taken this cycle.
  logic [CNT_W-1:0]  cnt_nxt;          // Occupancy after this edge.

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_r];

  // Next occupancy; a flush empties the buffer outright.
  always_comb begin
    if (flush) begin
      cnt_nxt = CNT_ZERO;
    end else begin
      cnt_nxt = count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Occupancy and registered handshake flags.
  // Single mode lets only one word in, which emulates a plain holding
  // register without a second storage structure.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count     <= CNT_ZERO;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count     <= cnt_nxt;
      out_valid <= (cnt_nxt != CNT_ZERO);
      in_ready  <= !flush && (single ? (cnt_nxt == CNT_ZERO)
                                     : (cnt_nxt != CNT_FULL));
    end
  end

  // Pointers move on accepted words only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (flush) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= !wr_r;
      end
      if (pop) begin
        rd_r <= !rd_r;
      end
    end
  end

  // One write port per entry.
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && (wr_r == 1'(i))) begin
        mem[i] <= in_data;
      end
    end
  end

endmodule : smb_pair_buf

`default_nettype wire

// *** testbench/smb_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// Checker on the top ports of the serial master, both clock domains.
module smb_props
  import smb_pkg::*;
(
  // Clocks and reset.
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              link_clk,
  // Control inputs.
  input wire logic              module_enable_bit,
  input wire logic              fifo_buffer_enable,
  input wire logic              clk_edge_select,
  input wire logic              clk_idle_high,
  input wire logic [2:0]        buffer_irq_select,
  input wire logic              irq_clear,
  // Outputs under watch.
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic              rx_buffer_full_flag,
  input wire logic              shifter_empty_flag,
  input wire logic              serial_irq_flag,
  input wire logic [STAT_W-1:0] serial_status_reg,
  input wire logic              sck,
  input wire logic              mosi,
  input wire logic              ss_n
);
  // Status mirrors inputs one edge late; the first edge still shows reset.
  property p_stat_sel;
    @(posedge clk) disable iff (rst) !$past(rst) |->
      serial_status_reg[STAT_SEL_MSB:STAT_SEL_LSB] == $past(buffer_irq_select);
  endproperty
  a_stat_sel: assert property (p_stat_sel) else $error("select field stale");
  property p_stat_mode;
    @(posedge clk) disable iff (rst) !$past(rst) |->
      serial_status_reg[STAT_FIFOEN_BIT] == $past(fifo_buffer_enable) &&
      serial_status_reg[STAT_ENABLE_BIT] == $past(module_enable_bit);
  endproperty
  a_stat_mode: assert property (p_stat_mode) else $error("mode bits stale");
  property p_stat_flags;
    @(posedge clk) disable iff (rst) !$past(rst) |->
      serial_status_reg[STAT_RXFULL_BIT] == rx_buffer_full_flag &&
      serial_status_reg[STAT_SREMPTY_BIT] == shifter_empty_flag;
  endproperty
  a_stat_flags: assert property (p_stat_flags) else $error("status flags");
  // The flag only drops on a clear or a disable.
  property p_sticky;
    @(posedge clk) disable iff (rst)
      serial_irq_flag && !irq_clear && module_enable_bit |=> serial_irq_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq flag dropped");
  property p_disable;
    @(posedge clk) disable iff (rst)
      !module_enable_bit [*2] |-> !tx_ready && !rx_valid;
  endproperty
  a_disable: assert property (p_disable) else $error("active while off");
  property p_std_flag;
    @(posedge clk) disable iff (rst)
      $rose(rx_valid) && !fifo_buffer_enable && module_enable_bit |->
      ##[0:1] (rx_buffer_full_flag && serial_irq_flag);
  endproperty
  a_std_flag: assert property (p_std_flag) else $error("no word flag");
  property p_sel101;
    @(posedge clk) disable iff (rst)
      $rose(serial_irq_flag) && fifo_buffer_enable &&
      buffer_irq_select == SEL_SR_EMPTY |-> ss_n;
  endproperty
  a_sel101: assert property (p_sel101) else $error("early shifter irq");
  property p_quiet;
    @(posedge clk) disable iff (rst)
      shifter_empty_flag && module_enable_bit |=> ss_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("word from empty");
  // With edge select one, output data may only move while the serial clock rests at idle.
  property p_edge;
    @(posedge link_clk) disable iff (rst)
      clk_edge_select && !ss_n && $changed(mosi) |-> sck == clk_idle_high;
  endproperty
  a_edge: assert property (p_edge) else $error("data moved on lead");
  c_word: cover property (@(posedge link_clk) disable iff (rst) $fell(ss_n));
  c_std:  cover property (@(posedge clk) disable iff (rst)
    $rose(serial_irq_flag) && !fifo_buffer_enable);
  c_tx0:  cover property (@(posedge clk) disable iff (rst)
    $rose(serial_irq_flag) && buffer_irq_select == SEL_TX_EMPTIED);
endmodule : smb_props

bind smb_master smb_props i_props (.clk(clk), .rst(rst), .link_clk(link_clk),
  .module_enable_bit(module_enable_bit), .irq_clear(irq_clear),
  .fifo_buffer_enable(fifo_buffer_enable), .clk_edge_select(clk_edge_select),
  .clk_idle_high(clk_idle_high), .buffer_irq_select(buffer_irq_select),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .ss_n(ss_n),
  .rx_buffer_full_flag(rx_buffer_full_flag), .sck(sck), .mosi(mosi),
  .shifter_empty_flag(shifter_empty_flag), .serial_irq_flag(serial_irq_flag),
  .serial_status_reg(serial_status_reg));

`default_nettype wire

// *** testbench/smb_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Serial slave: replies 16'hA500 plus its word count, records what it hears.
module smb_slave_model (
  // Link pins.
  input wire logic  link_clk,
  input wire logic  sck,
  input wire logic  mosi,
  input wire logic  ss_n,
  input wire logic  idle_high,
  output var logic  miso
);
  logic [15:0] tx_sh;   // Reply being shifted out.
  logic [15:0] rx_sh;   // Word being heard.
  int          n = 0;   // Completed words.
  int          bits = 0;
  logic [15:0] got[$];  // Every whole word heard.
  initial miso = 1'b0;
  // A word starts with its first bit already on the line.
  always @(negedge ss_n) begin
    bits = 0;
    tx_sh = 16'hA500 + n[15:0];
    miso = tx_sh[15];
  end
  // Sample on the leading edge, shift on the trailing one, MSB first.
  always @(sck) begin
    if (!ss_n && sck != idle_high) begin
      rx_sh = {rx_sh[14:0], mosi};
      bits++;
    end else if (!ss_n) begin
      tx_sh = {tx_sh[14:0], ~tx_sh[0]};
      miso = tx_sh[15];
    end
  end
  // Aborted words are not counted; an idle line toggles so stale bits show.
  always @(posedge ss_n) begin
    if (bits == 16) begin
      got.push_back(rx_sh);
      n++;
    end
  end
  always @(negedge link_clk) begin
    if (ss_n) miso = ~miso;
  end
endmodule : smb_slave_model

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

// Top bench: standard mode, every buffer event, sleep and disable.
module testbench;
  import smb_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst, module_enable_bit, fifo_buffer_enable, clk_edge_select;
  logic clk_idle_high, slave_select_enable, sleep_req, irq_clear;
  logic tx_valid, tx_ready, rx_valid, rx_ready, miso, sck, mosi, ss_n;
  logic rx_buffer_full_flag, shifter_empty_flag, serial_irq_flag;
  logic [2:0]        buffer_irq_select;
  logic [WORD_W-1:0] tx_data, rx_data, lf;
  logic [STAT_W-1:0] serial_status_reg;
  logic [WORD_W-1:0] sent[$];   // Words handed to the block, in order.
  int errors, compares, nrx, n;
  always #2 clk = ~clk;
  // Link clock starts off phase; its period is forty system cycles, so the offset stays fixed.
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  smb_master i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .module_enable_bit(module_enable_bit), .sleep_req(sleep_req),
    .fifo_buffer_enable(fifo_buffer_enable), .clk_edge_select(clk_edge_select),
    .clk_idle_high(clk_idle_high), .slave_select_enable(slave_select_enable),
    .buffer_irq_select(buffer_irq_select), .irq_clear(irq_clear),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_buffer_full_flag(rx_buffer_full_flag), .sck(sck), .mosi(mosi),
    .shifter_empty_flag(shifter_empty_flag), .miso(miso), .ss_n(ss_n),
    .serial_irq_flag(serial_irq_flag), .serial_status_reg(serial_status_reg));
  smb_slave_model i_slave (.link_clk(link_clk), .sck(sck), .mosi(mosi),
    .ss_n(ss_n), .idle_high(clk_idle_high), .miso(miso));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // Offers words back to back, each held until the block takes it.
  task automatic put(input int cnt);
    int k;
    for (int i = 0; i < cnt; i++) begin
      lf = lfsr(lf);
      tx_valid <= 1'b1;
      tx_data <= lf;
      sent.push_back(lf);
      k = 0;
      do begin @(posedge clk); k++; end while (tx_ready !== 1'b1 && k < 99);
    end
    tx_valid <= 1'b0;
  endtask : put
  // Reads words and compares each with the slave's numbered reply.
  task automatic get(input int cnt);
    int k;
    rx_ready <= 1'b1;
    for (int i = 0; i < cnt; i++) begin
      k = 0;
      do begin @(posedge clk); k++; end while (rx_valid !== 1'b1 && k < 99);
      check(rx_data, 16'hA500 + nrx[15:0]);
      nrx++;
    end
    rx_ready <= 1'b0;
  endtask : get
  // Bounded wait for the final edge; a stuck shifter counts as an error.
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (8) @(posedge clk);
    while (!(shifter_empty_flag === 1'b1 && ss_n === 1'b1) && k < 30000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 30000) errors++;
    repeat (8) @(posedge clk);
  endtask : wait_idle
  task automatic clear_irq;
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check(serial_irq_flag, 1'b0);
  endtask : clear_irq
  // Watchdog sized well above the fourteen words of traffic.
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    errors = 0; compares = 0; nrx = 0; lf = 16'h0055;
    rst = 1'b1; module_enable_bit = 1'b1; fifo_buffer_enable = 1'b0;
    clk_edge_select = 1'b1; clk_idle_high = 1'b0; slave_select_enable = 1'b0;
    sleep_req = 1'b0; buffer_irq_select = 3'h0; irq_clear = 1'b0;
    tx_valid = 1'b0; tx_data = 16'h0000; rx_ready = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(serial_status_reg, 16'h8080);
    // Standard mode: one word fills the buffer and flags at the last edge.
    for (int w = 0; w < 2; w++) begin
      put(1);
      wait_idle();
      check(rx_buffer_full_flag, 1'b1);
      check(serial_irq_flag, 1'b1);
      get(1);
      clear_irq();
    end
    fifo_buffer_enable <= 1'b1;
    clk_idle_high <= 1'b1;
    // Sleep with empty buffers must not produce any word.
    sleep_req <= 1'b1;
    repeat (2000) @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2000) @(posedge clk);
    check(rx_valid, 1'b0);
    // Every event selection; sleep holds words back so the buffer fills.
    // Pass eight repeats the transmit-empty event without slave select.
    for (int s = 0; s < 9; s++) begin
      buffer_irq_select <= (s == 8) ? 3'h6 : s[2:0];
      slave_select_enable <= (s > 4 && s < 8);
      clear_irq();
      n = (s == 2 || s == 3 || s == 7) ? 2 : 1;
      sleep_req <= 1'b1;
      put(n);
      repeat (300) @(posedge clk);
      check(ss_n, 1'b1);
      sleep_req <= 1'b0;
      wait_idle();
      if (s == 2) check(rx_buffer_full_flag, 1'b1);
      if (s == 0) get(n);
      repeat (6) @(posedge clk);
      check(serial_irq_flag, 1'b1);
      if (s != 0) get(n);
    end
    // Disable drops the flag and refuses words.
    module_enable_bit <= 1'b0;
    repeat (4) @(posedge clk);
    check(serial_irq_flag, 1'b0);
    check(tx_ready, 1'b0);
    module_enable_bit <= 1'b1;
    repeat (8) @(posedge clk);
    // The slave heard exactly the words sent, MSB first.
    check(i_slave.got.size(), sent.size());
    foreach (i_slave.got[i]) check(i_slave.got[i], sent[i]);
    stop_test();
  end
endmodule : testbench

`default_nettype wire
